//--- tvm_cfg.svh
// Register indices, field positions and reset values of the monitor block
`ifndef TVM_CFG_SVH
`define TVM_CFG_SVH
`define TVM_IDX_TEMP      6'h10
`define TVM_IDX_SUPPLY    6'h11
`define TVM_IDX_PERIODIC  6'h12
`define TVM_IDX_RATE_HI   6'h14
`define TVM_IDX_RATE_LO   6'h15
`define TVM_ADDR_W        8
`define TVM_RATE_W        16
`define TVM_CNT_W         17
`define TVM_B_FLAG        0
`define TVM_B_IE          1
`define TVM_B_STATUS      2
`define TVM_B_SENS_EN     3
`define TVM_B_ROUTE       5
`define TVM_B_FEAT_EN     2
`define TVM_B_OUT_EN      3
`define TVM_B_WAVE_SEL    4
`define TVM_B_CLK_SEL     7
`define TVM_RATE_RST      16'h0000
`endif

//--- tvm_pkg.sv
// Types shared by the temperature, supply and periodic timer block
package tvm_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tvm_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} tvm_apb_rsp_t;

	typedef struct packed {
		tvm_apb_rsp_t rsp;
		logic         analog_route_select;
		logic         temp_sensor_enable;
		logic         temp_irq_enable;
		logic         temp_change_flag;
		logic         supply_irq_enable;
		logic         supply_change_flag;
		logic         periodic_clock_select;
		logic         periodic_wave_select;
		logic         periodic_output_enable;
		logic         periodic_feature_enable;
		logic         periodic_irq_enable;
		logic         periodic_timeout_flag;
		logic [15:0]  periodic_rate;
		logic [16:0]  cnt;
		logic         aclk_prev;
		logic         aclk_half;
		logic [1:0]   temp_sync;
		logic [1:0]   supply_sync;
		logic         temp_over_status;
		logic         supply_low_status;
		logic         primed;
		logic         square;
		logic         pulse;
		logic         wave_pin;
		logic         wave_oe;
		logic         temp_irq;
		logic         supply_irq;
		logic         periodic_irq;
	} tvm_state_t;
endpackage

//--- tvm_api_ctrl.sv
// Temperature, low-voltage and periodic timer control registers on APB
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "tvm_cfg.svh"

// Behaviour
// - Route bit 5 selects bandgap (1) or temperature voltage (0) on the mux
// - Bit 3 enables the temperature sensor and bandgap amplifier
// - Bit 2 reads the over-temperature status; writes to it ignored
// - Temperature flag sets on any status change; cleared by writing 1
// - Temperature interrupt requested while flag and its enable are set
// - Supply register bit 2 reads the low-supply status; writes ignored
// - Supply flag sets on any status change; cleared by writing 1
// - Supply interrupt requested while flag and its enable are set
// - Clock select bit 7 writable only while feature off and not being set
// - Wave select 0 gives a one-tick high pulse at each period end
// - Wave select 1 gives a square wave toggling once per period
// - Waveform reaches the pin only with output and feature enable set
// - Feature enable bit 2 starts the timer; clearing it stops it
// - Timeout flag sets each period; cleared only by writing 1
// - Periodic interrupt requested while flag and its enable are set
// - Period is 2*(rate+1) ticks of bus clock or twice the slow clock
// - Rate registers ignore writes while the feature is enabled
module tvm_api_ctrl (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire tvm_pkg::tvm_apb_req_t apb_req,
	output tvm_pkg::tvm_apb_rsp_t     apb_rsp,
	input  wire logic                 aclk_in,
	input  wire logic                 temp_over_in,
	input  wire logic                 supply_low_in,
	output logic                      analog_route_select,
	output logic                      temp_sensor_enable,
	output logic                      temp_irq,
	output logic                      supply_irq,
	output logic                      periodic_irq,
	output logic                      periodic_wave_pin,
	output logic                      periodic_wave_oe
);
	import tvm_pkg::*;

	tvm_state_t st_ff;
	tvm_state_t nxt_st;

	logic        setup;
	logic        wr;
	logic [7:0]  wd;
	logic [5:0]  idx;
	logic        mapped;
	logic [7:0]  rd;
	logic        tick;
	logic        expire;
	logic        temp_evt;
	logic        supply_evt;
	logic        feat_rise;

	assign setup  = apb_req.psel && !apb_req.penable;
	// Refused addresses, misaligned ones included, must not reach any register
	assign wr     = apb_req.psel && apb_req.penable && st_ff.rsp.pready && apb_req.pwrite &&
		mapped;
	assign wd     = apb_req.pwdata[7:0];
	assign idx    = apb_req.paddr[7:2];
	assign mapped = (apb_req.paddr[1:0] == 2'h0) &&
		((idx == `TVM_IDX_TEMP) || (idx == `TVM_IDX_SUPPLY) || (idx == `TVM_IDX_PERIODIC) ||
		 (idx == `TVM_IDX_RATE_HI) || (idx == `TVM_IDX_RATE_LO));

	// Status change seen only once the synchronisers hold settled values
	assign temp_evt   = st_ff.primed && (st_ff.temp_sync[1] != st_ff.temp_over_status);
	assign supply_evt = st_ff.primed && (st_ff.supply_sync[1] != st_ff.supply_low_status);

	// Slow clock tick every second rising edge, i.e. twice its period
	assign tick   = st_ff.periodic_clock_select ? 1'b1 :
		(aclk_in && !st_ff.aclk_prev && st_ff.aclk_half);
	assign expire = st_ff.periodic_feature_enable && tick &&
		(st_ff.cnt == {st_ff.periodic_rate, 1'b1});
	assign feat_rise = wr && (idx == `TVM_IDX_PERIODIC) && wd[`TVM_B_FEAT_EN] &&
		!st_ff.periodic_feature_enable;

	always_comb begin
		rd = 8'h00;
		unique case (idx)
			`TVM_IDX_TEMP: begin
				rd[`TVM_B_ROUTE]   = st_ff.analog_route_select;
				rd[`TVM_B_SENS_EN] = st_ff.temp_sensor_enable;
				rd[`TVM_B_STATUS]  = st_ff.temp_over_status;
				rd[`TVM_B_IE]      = st_ff.temp_irq_enable;
				rd[`TVM_B_FLAG]    = st_ff.temp_change_flag;
			end
			`TVM_IDX_SUPPLY: begin
				rd[`TVM_B_STATUS] = st_ff.supply_low_status;
				rd[`TVM_B_IE]     = st_ff.supply_irq_enable;
				rd[`TVM_B_FLAG]   = st_ff.supply_change_flag;
			end
			`TVM_IDX_PERIODIC: begin
				rd[`TVM_B_CLK_SEL]  = st_ff.periodic_clock_select;
				rd[`TVM_B_WAVE_SEL] = st_ff.periodic_wave_select;
				rd[`TVM_B_OUT_EN]   = st_ff.periodic_output_enable;
				rd[`TVM_B_FEAT_EN]  = st_ff.periodic_feature_enable;
				rd[`TVM_B_IE]       = st_ff.periodic_irq_enable;
				rd[`TVM_B_FLAG]     = st_ff.periodic_timeout_flag;
			end
			`TVM_IDX_RATE_HI: rd = st_ff.periodic_rate[15:8];
			`TVM_IDX_RATE_LO: rd = st_ff.periodic_rate[7:0];
			default: rd = 8'h00;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		// Answer prepared in setup so pready and prdata come from flops
		nxt_st.rsp.pready  = setup;
		nxt_st.rsp.pslverr = setup && !mapped;
		nxt_st.rsp.prdata  = (setup && mapped && !apb_req.pwrite) ? {24'h000000, rd} : 32'h00000000;

		nxt_st.temp_sync   = {st_ff.temp_sync[0], temp_over_in};
		nxt_st.supply_sync = {st_ff.supply_sync[0], supply_low_in};
		nxt_st.temp_over_status  = st_ff.temp_sync[1];
		nxt_st.supply_low_status = st_ff.supply_sync[1];
		nxt_st.primed = 1'b1;
		nxt_st.aclk_prev = aclk_in;

		if (wr && idx == `TVM_IDX_TEMP) begin
			nxt_st.analog_route_select = wd[`TVM_B_ROUTE];
			nxt_st.temp_sensor_enable  = wd[`TVM_B_SENS_EN];
			nxt_st.temp_irq_enable     = wd[`TVM_B_IE];
			if (wd[`TVM_B_FLAG])
				nxt_st.temp_change_flag = 1'b0;
		end
		if (temp_evt)
			nxt_st.temp_change_flag = 1'b1;

		if (wr && idx == `TVM_IDX_SUPPLY) begin
			nxt_st.supply_irq_enable = wd[`TVM_B_IE];
			if (wd[`TVM_B_FLAG])
				nxt_st.supply_change_flag = 1'b0;
		end
		if (supply_evt)
			nxt_st.supply_change_flag = 1'b1;

		if (wr && idx == `TVM_IDX_PERIODIC) begin
			if (!st_ff.periodic_feature_enable && !wd[`TVM_B_FEAT_EN])
				nxt_st.periodic_clock_select = wd[`TVM_B_CLK_SEL];
			nxt_st.periodic_wave_select    = wd[`TVM_B_WAVE_SEL];
			nxt_st.periodic_output_enable  = wd[`TVM_B_OUT_EN];
			nxt_st.periodic_feature_enable = wd[`TVM_B_FEAT_EN];
			nxt_st.periodic_irq_enable     = wd[`TVM_B_IE];
			if (wd[`TVM_B_FLAG])
				nxt_st.periodic_timeout_flag = 1'b0;
		end
		if (wr && !st_ff.periodic_feature_enable) begin
			if (idx == `TVM_IDX_RATE_HI)
				nxt_st.periodic_rate[15:8] = wd;
			if (idx == `TVM_IDX_RATE_LO)
				nxt_st.periodic_rate[7:0] = wd;
		end

		// Timer
		if (!st_ff.periodic_feature_enable || feat_rise) begin
			nxt_st.cnt       = 17'h00000;
			nxt_st.aclk_half = 1'b0;
			nxt_st.square    = 1'b0;
			nxt_st.pulse     = 1'b0;
		end else begin
			if (aclk_in && !st_ff.aclk_prev)
				nxt_st.aclk_half = !st_ff.aclk_half;
			if (tick) begin
				nxt_st.cnt   = expire ? 17'h00000 : st_ff.cnt + 17'h00001;
				nxt_st.pulse = expire;
				if (expire)
					nxt_st.square = !st_ff.square;
			end
		end
		if (expire)
			nxt_st.periodic_timeout_flag = 1'b1;

		nxt_st.wave_oe  = st_ff.periodic_output_enable && st_ff.periodic_feature_enable;
		nxt_st.wave_pin = nxt_st.wave_oe &&
			(st_ff.periodic_wave_select ? st_ff.square : st_ff.pulse);

		nxt_st.temp_irq     = nxt_st.temp_change_flag && nxt_st.temp_irq_enable;
		nxt_st.supply_irq   = nxt_st.supply_change_flag && nxt_st.supply_irq_enable;
		nxt_st.periodic_irq = nxt_st.periodic_timeout_flag && nxt_st.periodic_irq_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.periodic_rate <= `TVM_RATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign apb_rsp             = st_ff.rsp;
	assign analog_route_select = st_ff.analog_route_select;
	assign temp_sensor_enable  = st_ff.temp_sensor_enable;
	assign temp_irq            = st_ff.temp_irq;
	assign supply_irq          = st_ff.supply_irq;
	assign periodic_irq        = st_ff.periodic_irq;
	assign periodic_wave_pin   = st_ff.wave_pin;
	assign periodic_wave_oe    = st_ff.wave_oe;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_route_follows_write: assert property (
		wr && idx == `TVM_IDX_TEMP |=> analog_route_select == $past(wd[`TVM_B_ROUTE]))
		else $error("route select did not follow write");
	a_sensor_en_write: assert property (
		wr && idx == `TVM_IDX_TEMP |=> temp_sensor_enable == $past(wd[`TVM_B_SENS_EN]))
		else $error("sensor enable did not follow write");
	a_temp_status_sync: assert property (
		$stable(temp_over_in) [*3] |-> st_ff.temp_over_status == $past(temp_over_in, 2))
		else $error("temperature status not synchronised input");
	a_temp_flag_set: assert property (
		temp_evt |=> st_ff.temp_change_flag)
		else $error("temperature flag missed a change");
	a_temp_irq_req: assert property (
		st_ff.temp_change_flag && st_ff.temp_irq_enable |-> temp_irq)
		else $error("temperature request missing");
	a_supply_status: assert property (
		wr && idx == `TVM_IDX_SUPPLY
		|=> st_ff.supply_low_status == $past(st_ff.supply_sync[1]))
		else $error("supply status written");
	a_supply_flag_hold: assert property (
		st_ff.supply_change_flag && !(wr && idx == `TVM_IDX_SUPPLY && wd[`TVM_B_FLAG])
		|=> st_ff.supply_change_flag)
		else $error("supply flag lost without clear");
	a_supply_irq_req: assert property (
		supply_irq |-> st_ff.supply_change_flag && st_ff.supply_irq_enable)
		else $error("spurious supply request");
	a_clock_sel_lock: assert property (
		st_ff.periodic_feature_enable |=> $stable(st_ff.periodic_clock_select))
		else $error("clock select changed while enabled");
	a_pin_gated: assert property (
		periodic_wave_pin |-> $past(st_ff.periodic_output_enable && st_ff.periodic_feature_enable))
		else $error("wave on pin while not enabled");
	a_bus_tick_period: assert property (
		st_ff.periodic_clock_select && st_ff.periodic_feature_enable &&
		st_ff.periodic_rate == 16'h0000 && expire
		|=> !expire ##1 expire || !st_ff.periodic_feature_enable)
		else $error("minimum bus clock period not two cycles");
	a_rate_locked: assert property (
		st_ff.periodic_feature_enable |=> $stable(st_ff.periodic_rate))
		else $error("rate changed while enabled");
	a_timeout_flag: assert property (
		expire |=> st_ff.periodic_timeout_flag && periodic_irq == st_ff.periodic_irq_enable)
		else $error("timeout flag not set on expiry");
	a_apb_answer: assert property (
		setup |=> apb_rsp.pready)
		else $error("no answer after setup");
endmodule // tvm_api_ctrl

//--- tb.sv
// Self-checking bench for the temperature, supply and periodic timer registers
`timescale 1ns/100ps
module tb;
	import tvm_pkg::*;
	logic         pclk, presetn, aclk_in, temp_over_in, supply_low_in;
	tvm_apb_req_t req;
	tvm_apb_rsp_t rsp;
	logic         route, sens, t_irq, s_irq, p_irq, pin, oe, er;
	logic [31:0]  rdv;
	int           err_count, total_checks, c;

	tvm_api_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.aclk_in(aclk_in), .temp_over_in(temp_over_in), .supply_low_in(supply_low_in),
		.analog_route_select(route), .temp_sensor_enable(sens), .temp_irq(t_irq),
		.supply_irq(s_irq), .periodic_irq(p_irq), .periodic_wave_pin(pin),
		.periodic_wave_oe(oe));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Slow clock at a quarter of the bus clock
	always begin
		repeat (2) @(posedge pclk);
		aclk_in <= ~aclk_in;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (rsp.pready !== 1'b1 && i < 16);
		if (i >= 16) begin
			err_count++;
			$display("mismatch %0t no ready", $time);
			conclude();
		end
		rdv = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(negedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdv, e, "read data");
	endtask

	// Bounded wait for the pin (s=1) or the periodic request (s=0) to reach v
	task automatic wt(input int s, input logic v);
		for (int i = 0; i < 400; i++) begin
			if ((s ? pin : p_irq) === v)
				return;
			@(negedge pclk);
		end
		err_count++;
		$display("mismatch %0t wait ran out", $time);
		conclude();
	endtask

	task automatic width(input logic v, output int n);
		wt(1, v);
		n = 0;
		while (pin === v && n < 400) begin
			@(negedge pclk);
			n++;
		end
	endtask

	// Status change, flag set, write-one clear and request gating of one register
	task automatic ftest(input int i, input logic [7:0] a, input logic [7:0] cb);
		wr(a, cb | 8'h04);
		rd(a, cb);
		@(posedge pclk);
		if (i) supply_low_in <= 1'b1; else temp_over_in <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(a, cb | 8'h05);
		chk(i ? s_irq : t_irq, 1, "request on");
		wr(a, cb);
		rd(a, cb | 8'h05);
		wr(a, cb | 8'h01);
		rd(a, cb | 8'h04);
		chk(i ? s_irq : t_irq, 0, "request off");
		wr(a, cb & 8'hfd);
		@(posedge pclk);
		if (i) supply_low_in <= 1'b0; else temp_over_in <= 1'b0;
		repeat (6) @(posedge pclk);
		rd(a, (cb & 8'hfd) | 8'h01);
		chk(i ? s_irq : t_irq, 0, "request masked");
		wr(a, cb | 8'h01);
		rd(a, cb);
	endtask

	initial begin
		presetn = 1'b0;
		req = '0;
		aclk_in = 1'b0;
		temp_over_in = 1'b0;
		supply_low_in = 1'b0;
		err_count = 0;
		total_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h40, 0);
		rd(8'h44, 0);
		rd(8'h48, 0);
		rd(8'h50, 0);
		rd(8'h54, 0);
		ftest(0, 8'h40, 8'h2a);
		chk(route, 1, "route bandgap");
		chk(sens, 1, "sensor on");
		ftest(1, 8'h44, 8'h02);
		wr(8'h40, 8'h08);
		chk(route, 0, "route temperature");
		chk(sens, 1, "sensor kept");
		wr(8'h40, 8'h00);
		chk(sens, 0, "sensor off");
		apb(1'b0, 8'h4c, 0);
		chk(er, 1, "unmapped error");
		chk(rdv, 0, "unmapped data");
		apb(1'b0, 8'h41, 0);
		chk(er, 1, "misaligned error");
		apb(1'b1, 8'h41, 32'h0000_0008);
		chk(er, 1, "misaligned write error");
		rd(8'h40, 8'h00);
		wr(8'h50, 8'h00);
		wr(8'h54, 8'h03);
		rd(8'h54, 8'h03);
		wr(8'h48, 8'h80);
		rd(8'h48, 8'h80);
		wr(8'h48, 8'h1e);
		rd(8'h48, 8'h9e);
		wt(0, 1'b1);
		rd(8'h48, 8'h9f);
		chk(oe, 1, "pin enabled");
		wt(1, 1'b0);
		width(1'b1, c);
		chk(c, 8, "square half period");
		wr(8'h54, 8'h05);
		rd(8'h54, 8'h03);
		wr(8'h48, 8'h0f);
		repeat (4) @(negedge pclk);
		wt(1, 1'b0);
		width(1'b1, c);
		chk(c, 1, "pulse width");
		width(1'b0, c);
		chk(c, 7, "pulse spacing");
		wr(8'h48, 8'h07);
		@(negedge pclk);
		chk(oe, 0, "pin disabled");
		repeat (10) @(negedge pclk);
		chk(pin, 0, "pin quiet");
		wr(8'h48, 8'h02);
		rd(8'h48, 8'h83);
		wr(8'h48, 8'h83);
		rd(8'h48, 8'h82);
		chk(p_irq, 0, "periodic request off");
		wr(8'h48, 8'h00);
		wr(8'h48, 8'h1c);
		wt(1, 1'b0);
		width(1'b1, c);
		chk(c, 64, "slow clock period");
		conclude();
	end
endmodule // tb
